// >>> include/smms_consts.svh
`ifndef SMMS_CONSTS_SVH
`define SMMS_CONSTS_SVH
// ==========================================
// mode status codes
`define SMMS_CODE_OFF 3'h0
`define SMMS_CODE_MAN 3'h1
`define SMMS_CODE_M1 3'h2
`define SMMS_CODE_M2A 3'h3
`define SMMS_CODE_M2B 3'h4
`define SMMS_CODE_M3 3'h5
// ==========================================
// disabled input number
`define SMMS_INPUT_DISABLED 8'hFF
// ==========================================
// timing
`define SMMS_CLK_PERIOD_NS 10
`define SMMS_TICK_NS 1000000
`define SMMS_TICK_CYCLES ((`SMMS_TICK_NS + `SMMS_CLK_PERIOD_NS - 1) / `SMMS_CLK_PERIOD_NS)
`define SMMS_REACT_RESET 16'h0064
`endif

// >>> include/smms_pkg.sv
package smms_pkg;
  // ==========================================
  // monitoring mode derived from inputs
  typedef enum logic [2:0] {
    SMMS_MODE_OFF = 3'b000,
    SMMS_MODE_MAN = 3'b001,
    SMMS_MODE_M1 = 3'b010,
    SMMS_MODE_M2A = 3'b011,
    SMMS_MODE_M2B = 3'b100,
    SMMS_MODE_M3 = 3'b101
  } smms_mode_t;
  // ==========================================
  // stop sequencer states
  typedef enum logic [1:0] {
    SMMS_STOP_RUN = 2'b00,
    SMMS_STOP_DECEL = 2'b01,
    SMMS_STOP_OFF = 2'b10
  } smms_stop_t;
endpackage : smms_pkg

// >>> verilog/smms_tick_gen.sv
`timescale 1ns/10ps
`include "smms_consts.svh"
// ==========================================
// periodic tick for the reaction timer
module smms_tick_gen import smms_pkg::*; #(
  parameter int TICK_CYCLES = `SMMS_TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  output logic tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } smms_tick_state_t;
  smms_tick_state_t st;
  smms_tick_state_t next_st;
  // count down, pulse on wrap
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'h0) begin
      next_st.cnt = 32'(TICK_CYCLES - 1);
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt - 32'h1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick_o = st.tick;
endmodule : smms_tick_gen

// >>> verilog/smms_mode_select.sv
`timescale 1ns/10ps
`include "smms_consts.svh"
module smms_mode_select import smms_pkg::*; #(
  // plane count and limit widths may differ between products
  parameter int NUM_PLANES = 8,
  parameter int SPD_W = 16,
  parameter int TRQ_W = 16,
  parameter int TICK_CYCLES = `SMMS_TICK_CYCLES
) (
  // clock and asynchronous reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // configuration, same clock domain, read as it stands
  input wire logic monitor_enable_i,
  // controller mode and safety input pins, synchronised inside
  input wire logic ctrl_manual_i,
  input wire logic safety_input_first_i,
  input wire logic safety_input_second_i,
  // input numbers, all ones marks an input as unused
  input wire logic [7:0] safety_input_number_cfg_first_i,
  input wire logic [7:0] safety_input_number_cfg_second_i,
  input wire logic [15:0] reaction_time_setting_i,
  // per-mode limit settings, passed through untouched
  input wire logic [SPD_W-1:0] speed_limit_table_first_i,
  input wire logic [SPD_W-1:0] speed_limit_table_second_i,
  input wire logic [SPD_W-1:0] manual_speed_limit_i,
  input wire logic [TRQ_W-1:0] torque_width_limit_mode_two_i,
  input wire logic [TRQ_W-1:0] torque_width_limit_mode_three_i,
  input wire logic [TRQ_W-1:0] torque_width_limit_manual_i,
  // one 3-bit mode code per plane, plane 0 lowest
  input wire logic [3*NUM_PLANES-1:0] plane_mode_assignment_i,
  // stop request and drive feedback pins, synchronised inside
  input wire logic estop_i,
  input wire logic robot_moving_i,
  input wire logic speed_cmd_zero_i,
  // mode report, both copies from two flops loaded with the same code
  output logic [2:0] mode_code_output_o,
  output logic [2:0] mode_status_value_o,
  // monitoring selection
  output logic speed_limit_monitor_en_o,
  output logic [SPD_W-1:0] speed_limit_o,
  output logic torque_width_monitor_en_o,
  output logic [TRQ_W-1:0] torque_width_limit_o,
  output logic [NUM_PLANES-1:0] position_limit_monitor_en_o,
  // stop sequencing
  output logic controlled_stop_function_o,
  output logic torque_off_function_o,
  output logic brake_engage_o
);
  // ==========================================
  // state
  // all state in one packed word, registered by a single process
  typedef struct packed {
    // synchroniser pairs, bit 1 is the settled copy
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s_man;
    logic [1:0] s_stop;
    logic [1:0] s_moving;
    logic [1:0] s_zero;
    // selected mode and reaction timer
    smms_mode_t cur;
    smms_mode_t pend;
    logic timing;
    logic [15:0] elapsed;
    // registered outputs
    logic [2:0] code;
    logic [2:0] status;
    logic spd_en;
    logic [SPD_W-1:0] spd;
    logic trq_en;
    logic [TRQ_W-1:0] trq;
    logic [NUM_PLANES-1:0] planes;
    // stop sequencer
    smms_stop_t stop;
    logic ss1;
    logic torque_off_function;
    logic brake;
  } smms_state_t;
  // st is the registered copy, next_st what the next edge loads
  smms_state_t st;
  smms_state_t next_st;
  // one-cycle pulse from the tick divider
  logic tick;
  // ==========================================
  // helpers
  // all ones stands for an input number of minus one
  function automatic logic input_unused(input logic [7:0] number);
    input_unused = (number == `SMMS_INPUT_DISABLED);
  endfunction : input_unused
  // an unused input never counts as off, whatever its pin shows
  function automatic logic input_off(input logic level, input logic unused);
    input_off = !unused && !level;
  endfunction : input_off
  // true for the six encodings the selector can produce
  function automatic logic legal_mode(input smms_mode_t m);
    legal_mode = (m inside {SMMS_MODE_OFF, SMMS_MODE_MAN, SMMS_MODE_M1, SMMS_MODE_M2A,
                            SMMS_MODE_M2B, SMMS_MODE_M3});
  endfunction : legal_mode
  // the tick that brings the count to the setting ends the wait; 0 acts as 1
  function automatic logic react_done(input logic [15:0] elapsed,
                                      input logic [15:0] setting);
    react_done = (elapsed + 16'h1 >= setting);
  endfunction : react_done
  // manual wins outright, then look at which inputs are off
  function automatic smms_mode_t derive_mode(input logic manual, input logic in1,
                                             input logic in2, input logic dis1,
                                             input logic dis2);
    logic off1;
    logic off2;
    off1 = input_off(in1, dis1);
    off2 = input_off(in2, dis2);
    if (manual) begin
      derive_mode = SMMS_MODE_MAN;
    end else if (off1 && off2) begin
      derive_mode = SMMS_MODE_M3;
    end else if (off1) begin
      derive_mode = SMMS_MODE_M2A;
    end else if (off2) begin
      derive_mode = SMMS_MODE_M2B;
    end else begin
      derive_mode = SMMS_MODE_M1;
    end
  endfunction : derive_mode
  // report code for a mode; unused encodings report off
  function automatic logic [2:0] mode_code(input smms_mode_t m);
    case (m)
      SMMS_MODE_MAN: mode_code = `SMMS_CODE_MAN;
      SMMS_MODE_M1: mode_code = `SMMS_CODE_M1;
      SMMS_MODE_M2A: mode_code = `SMMS_CODE_M2A;
      SMMS_MODE_M2B: mode_code = `SMMS_CODE_M2B;
      SMMS_MODE_M3: mode_code = `SMMS_CODE_M3;
      default: mode_code = `SMMS_CODE_OFF;
    endcase
  endfunction : mode_code
  // ==========================================
  // tick source for the reaction timer
  smms_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );
  // ==========================================
  // next-state logic
  always_comb begin
    // scratch values, set at the top so no latch can form
    smms_mode_t target;
    smms_mode_t eff;
    next_st = st;
    target = SMMS_MODE_OFF;
    eff = SMMS_MODE_OFF;
    // two-flop synchronisers, first stage read only by the second
    next_st.s1 = {st.s1[0], safety_input_first_i};
    next_st.s2 = {st.s2[0], safety_input_second_i};
    next_st.s_man = {st.s_man[0], ctrl_manual_i};
    next_st.s_stop = {st.s_stop[0], estop_i};
    next_st.s_moving = {st.s_moving[0], robot_moving_i};
    next_st.s_zero = {st.s_zero[0], speed_cmd_zero_i};
    // target is what the settled inputs ask for right now
    target = derive_mode(st.s_man[1], st.s1[1], st.s2[1],
                         input_unused(safety_input_number_cfg_first_i),
                         input_unused(safety_input_number_cfg_second_i));
    // disable, first enable, upset recovery, cancel, restart, then count ticks
    if (!monitor_enable_i) begin
      // disabled: drop straight to off, retake current inputs when enabled
      next_st.cur = SMMS_MODE_OFF;
      next_st.timing = 1'b0;
      next_st.elapsed = 16'h0;
    end else if (st.cur == SMMS_MODE_OFF) begin
      // first enable takes the inputs as they stand, no history to delay
      next_st.cur = target;
    end else if (!legal_mode(st.cur)) begin
      // an unused encoding can only come from an upset; retake the inputs at once
      next_st.cur = target;
      next_st.timing = 1'b0;
      next_st.elapsed = 16'h0;
    end else if (target == st.cur) begin
      next_st.timing = 1'b0;
      next_st.elapsed = 16'h0;
    end else if (!st.timing || target != st.pend) begin
      next_st.timing = 1'b1;
      next_st.pend = target;
      next_st.elapsed = 16'h0;
    end else if (tick) begin
      if (react_done(st.elapsed, reaction_time_setting_i)) begin
        next_st.cur = st.pend;
        next_st.timing = 1'b0;
        next_st.elapsed = 16'h0;
      end else begin
        next_st.elapsed = st.elapsed + 16'h1;
      end
    end
    // report follows the mode being registered, so code and limits move together
    eff = next_st.cur;
    next_st.code = mode_code(eff);
    next_st.status = mode_code(eff);
    // speed limit per mode, 2A and 2B share
    // mode 1 and off fall to the default and switch both monitors off
    next_st.spd_en = 1'b1;
    next_st.spd = '0;
    next_st.trq_en = 1'b1;
    next_st.trq = '0;
    case (eff)
      SMMS_MODE_M2A, SMMS_MODE_M2B: begin
        next_st.spd = speed_limit_table_first_i;
        next_st.trq = torque_width_limit_mode_two_i;
      end
      SMMS_MODE_M3: begin
        next_st.spd = speed_limit_table_second_i;
        next_st.trq = torque_width_limit_mode_three_i;
      end
      SMMS_MODE_MAN: begin
        next_st.spd = manual_speed_limit_i;
        next_st.trq = torque_width_limit_manual_i;
      end
      default: begin
        next_st.spd_en = 1'b0;
        next_st.trq_en = 1'b0;
      end
    endcase
    // plane select compares full mode, keeping 2A and 2B apart
    for (int i = 0; i < NUM_PLANES; i++) begin
      next_st.planes[i] = (eff != SMMS_MODE_OFF) &&
                          (plane_mode_assignment_i[3*i +: 3] == 3'(eff));
    end
    // emergency stop sequencing
    case (st.stop)
      SMMS_STOP_RUN: begin
        // a moving robot is brought down first, a standing one is cut at once
        if (st.s_stop[1]) begin
          if (st.s_moving[1] && !st.s_zero[1]) begin
            next_st.stop = SMMS_STOP_DECEL;
          end else begin
            next_st.stop = SMMS_STOP_OFF;
          end
        end
      end
      SMMS_STOP_DECEL: begin
        // wait for the speed command to reach zero
        if (st.s_zero[1]) begin
          next_st.stop = SMMS_STOP_OFF;
        end
      end
      SMMS_STOP_OFF: begin
        // energy stays cut until the stop request is released
        if (!st.s_stop[1]) begin
          next_st.stop = SMMS_STOP_RUN;
        end
      end
      // unused encoding: fail safe by cutting energy
      default: next_st.stop = SMMS_STOP_OFF;
    endcase
    // outputs decoded from the next stop state so they move with it
    next_st.ss1 = (next_st.stop == SMMS_STOP_DECEL);
    next_st.torque_off_function = (next_st.stop == SMMS_STOP_OFF);
    next_st.brake = (next_st.stop == SMMS_STOP_OFF);
  end
  // ==========================================
  // registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================
  // outputs straight from flops
  // mode report, two flops holding the same code value
  assign mode_code_output_o = st.code;
  assign mode_status_value_o = st.status; // no write path exists
  // monitoring selection
  assign speed_limit_monitor_en_o = st.spd_en;
  assign speed_limit_o = st.spd;
  assign torque_width_monitor_en_o = st.trq_en;
  assign torque_width_limit_o = st.trq;
  assign position_limit_monitor_en_o = st.planes;
  // stop sequencing
  assign controlled_stop_function_o = st.ss1;
  assign torque_off_function_o = st.torque_off_function;
  assign brake_engage_o = st.brake;
endmodule : smms_mode_select

// >>> testbench/smms_mode_select_chk.sv
`timescale 1ns/10ps
// ==========================================
// port-level checks of the mode selector
module smms_mode_select_chk #(
  parameter int NUM_PLANES = 8,
  parameter int SPD_W = 16,
  parameter int TRQ_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic monitor_enable_i,
  input wire logic estop_i,
  input wire logic robot_moving_i,
  input wire logic [SPD_W-1:0] speed_limit_table_second_i,
  input wire logic [TRQ_W-1:0] torque_width_limit_mode_two_i,
  input wire logic [3*NUM_PLANES-1:0] plane_mode_assignment_i,
  input wire logic [2:0] mode_code_output_o,
  input wire logic [2:0] mode_status_value_o,
  input wire logic speed_limit_monitor_en_o,
  input wire logic [SPD_W-1:0] speed_limit_o,
  input wire logic torque_width_monitor_en_o,
  input wire logic [TRQ_W-1:0] torque_width_limit_o,
  input wire logic [NUM_PLANES-1:0] position_limit_monitor_en_o,
  input wire logic controlled_stop_function_o,
  input wire logic torque_off_function_o,
  input wire logic brake_engage_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_STATUS_COPY: assert property (mode_status_value_o == mode_code_output_o)
    else $error("status value differs from mode code");
  AST_OFF_CODE: assert property (!monitor_enable_i |=> mode_code_output_o == 3'h0)
    else $error("code not zero while disabled");
  AST_M1_NO_MON: assert property (mode_code_output_o == 3'h2
    |-> !speed_limit_monitor_en_o && !torque_width_monitor_en_o)
    else $error("monitoring active in mode one");
  AST_M3_SPEED: assert property (mode_code_output_o == 3'h5
    |-> speed_limit_monitor_en_o && speed_limit_o == speed_limit_table_second_i)
    else $error("wrong speed limit in mode three");
  AST_M2_TORQUE: assert property (mode_code_output_o inside {3'h3, 3'h4}
    |-> torque_width_monitor_en_o && torque_width_limit_o == torque_width_limit_mode_two_i)
    else $error("wrong torque width limit in mode two");
  AST_PLANE_ZERO: assert property (mode_code_output_o != 3'h0
    |-> position_limit_monitor_en_o[0] == (plane_mode_assignment_i[2:0] == mode_code_output_o))
    else $error("plane zero selection wrong");
  AST_OFF_BRAKE: assert property (torque_off_function_o
    |-> brake_engage_o && !controlled_stop_function_o)
    else $error("torque off without brake");
  AST_STILL_ESTOP: assert property (($rose(estop_i) && !robot_moving_i)
    ##1 (estop_i && !robot_moving_i) [*4] |=> torque_off_function_o)
    else $error("standing robot not cut off");
endmodule : smms_mode_select_chk

bind smms_mode_select smms_mode_select_chk #(.NUM_PLANES(NUM_PLANES), .SPD_W(SPD_W),
  .TRQ_W(TRQ_W)) u_chk (.sys_clk_i, .rst_b_i, .monitor_enable_i, .estop_i, .robot_moving_i,
  .speed_limit_table_second_i, .torque_width_limit_mode_two_i, .plane_mode_assignment_i,
  .mode_code_output_o, .mode_status_value_o, .speed_limit_monitor_en_o, .speed_limit_o,
  .torque_width_monitor_en_o, .torque_width_limit_o, .position_limit_monitor_en_o,
  .controlled_stop_function_o, .torque_off_function_o, .brake_engage_o);

// >>> testbench/smms_drive_model.sv
`timescale 1ns/10ps
// ==========================================
// robot drive: speed command ramps down only while the stop runs
module smms_drive_model (
  input wire logic sys_clk_i,
  input wire logic load_i,
  input wire logic [3:0] start_speed_i,
  input wire logic controlled_stop_function_i,
  output logic robot_moving_o,
  output logic speed_cmd_zero_o
);
  logic [3:0] speed = 4'h0;
  // one step per clock, so the stop lasts several cycles
  always @(posedge sys_clk_i) begin
    if (load_i) begin
      speed <= #1 start_speed_i;
    end else if (controlled_stop_function_i && speed != 4'h0) begin
      speed <= #1 speed - 4'h1;
    end
  end
  assign robot_moving_o = (speed != 4'h0);
  assign speed_cmd_zero_o = (speed == 4'h0);
endmodule : smms_drive_model

// >>> testbench/safety_monitoring_mode_selector_test.sv
`timescale 1ns/10ps
module safety_monitoring_mode_selector_test;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, en = 1'b0, man = 1'b1, s1 = 1'b1, s2 = 1'b1;
  logic estop = 1'b0, load = 1'b0, slm, twm, css, torque_off_function, brk, mov, zero;
  logic [7:0] cfg1 = 8'h01, cfg2 = 8'h02, pos;
  logic [15:0] react = 16'h0003, spd, trq;
  logic [15:0] lim [6] = '{16'h0300, 16'h0200, 16'h0080, 16'h0040, 16'h0030, 16'h0020};
  logic [7:0] posx [6] = '{8'h00, 8'h10, 8'h02, 8'h01, 8'h08, 8'h04};
  logic [2:0] code, stat;
  int mismatches = 0, check_count = 0, cycles = 0;

  smms_mode_select #(.TICK_CYCLES(4)) DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .monitor_enable_i(en), .ctrl_manual_i(man), .safety_input_first_i(s1),
    .safety_input_second_i(s2), .safety_input_number_cfg_first_i(cfg1),
    .safety_input_number_cfg_second_i(cfg2), .reaction_time_setting_i(react),
    .speed_limit_table_first_i(lim[0]), .speed_limit_table_second_i(lim[1]),
    .manual_speed_limit_i(lim[2]), .torque_width_limit_mode_two_i(lim[3]),
    .torque_width_limit_mode_three_i(lim[4]), .torque_width_limit_manual_i(lim[5]),
    .plane_mode_assignment_i(24'hDB1953), .estop_i(estop), .robot_moving_i(mov),
    .speed_cmd_zero_i(zero), .mode_code_output_o(code), .mode_status_value_o(stat),
    .speed_limit_monitor_en_o(slm), .speed_limit_o(spd), .torque_width_monitor_en_o(twm),
    .torque_width_limit_o(trq), .position_limit_monitor_en_o(pos),
    .controlled_stop_function_o(css), .torque_off_function_o(torque_off_function), .brake_engage_o(brk));
  smms_drive_model u_drive (.sys_clk_i(sys_clk_i), .load_i(load), .start_speed_i(4'h5),
    .controlled_stop_function_i(css), .robot_moving_o(mov), .speed_cmd_zero_o(zero));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================
  // helpers; inputs always change 1 ns after the edge
  task automatic step(int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic check(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // code must arrive no earlier than lo and before hi cycles
  task automatic expect_code(logic [2:0] exp, int lo, int hi);
    int n;
    n = 0;
    while (code !== exp && n < hi) begin
      step();
      n++;
    end
    check({n >= lo, n < hi}, 2'b11);
    check(stat, exp);
    check(pos, posx[exp]);
  endtask : expect_code
  task automatic hold(logic [2:0] exp, int n);
    repeat (n) begin
      step();
      check(code, exp);
    end
  endtask : hold
  // wait up to hi cycles for torque off (pick_sto) or for the controlled stop
  task automatic wait_on(input bit pick_sto, input int hi);
    repeat (hi) if ((pick_sto ? torque_off_function : css) !== 1'b1) step();
  endtask : wait_on
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==========================================
  // tests
  initial begin
    step(10);
    rst_b_i = 1'b1;
    step(4);
    check(code, 3'h0);
    en = 1'b1;
    expect_code(3'h1, 0, 4);
    check({slm, spd}, {1'b1, lim[2]});
    check({twm, trq}, {1'b1, lim[5]});
    s1 = 1'b0;
    hold(3'h1, 30);
    $display("test manual done");
    man = 1'b0;
    expect_code(3'h3, 11, 24);
    check({twm, trq}, {1'b1, lim[3]});
    check({slm, spd}, {1'b1, lim[0]});
    s1 = 1'b1;
    expect_code(3'h2, 11, 24);
    check({slm, twm}, 2'b00);
    s1 = 1'b0;
    step(3);
    s1 = 1'b1;
    hold(3'h2, 30);
    s1 = 1'b0;
    step(6);
    s2 = 1'b0;
    expect_code(3'h5, 11, 24);
    check({twm, trq}, {1'b1, lim[4]});
    check({slm, spd}, {1'b1, lim[1]});
    $display("test automatic done");
    cfg1 = 8'hFF;
    s2 = 1'b1;
    expect_code(3'h2, 11, 24);
    s2 = 1'b0;
    expect_code(3'h4, 11, 24);
    check({twm, trq}, {1'b1, lim[3]});
    en = 1'b0;
    expect_code(3'h0, 0, 3);
    $display("test disable done");
    load = 1'b1;
    step();
    load = 1'b0;
    estop = 1'b1;
    wait_on(1'b0, 6);
    check({css, torque_off_function}, 2'b10);
    wait_on(1'b1, 16);
    check({torque_off_function, brk, css}, 3'b110);
    estop = 1'b0;
    step(6);
    check({torque_off_function, brk}, 2'b00);
    estop = 1'b1;
    wait_on(1'b1, 6);
    check({torque_off_function, css}, 2'b10);
    $display("test stop done");
    tally_and_finish();
  end
endmodule : safety_monitoring_mode_selector_test
